//--- rtl/mwf_warning_top.sv
// Warning flag register bank for temperature, supply and external monitors.
`default_nettype none
// Summary of operation
// - Temperature high flag is set when the last result is above its high threshold and cleared otherwise.
// - Temperature low flag is set when the last result is below its low threshold and cleared otherwise.
// - Supply high flag is set when the last supply result is above its high threshold and cleared otherwise.
// - Supply low flag is forced to one while the supply is under the power-on trip level.
// - Supply low flag clears itself when a supply conversion ends above the low threshold.
// - After reset the primary register holds only the supply low flag and reads 10h.
// - Monitor A high flag follows whether its last result is above its high threshold.
// - Monitor A low flag follows whether its last result is below its low threshold.
// - Monitor B high flag follows whether its last result is above its high threshold.
// - Monitor B low flag follows whether its last result is below its low threshold.
// - Monitor C high flag sits in bit 7 of the secondary register and follows its high compare.
// - Monitor C low flag follows whether its last result is below its low threshold.
// - Monitor D high flag follows whether its last result is above its high threshold.
// - Monitor D low flag follows whether its last result is below its low threshold.
module mwf_warning_top (
    input  wire logic                                  core_clk,
    input  wire logic                                  srst,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [mwf_pkg::ADDR_W-1:0]            paddr,
    input  wire logic [31:0]                           pwdata,
    input  wire logic [3:0]                            pstrb,
    output logic                                       pready,
    output logic [31:0]                                prdata,
    output logic                                       pslverr,
    input  wire logic                                  convValid,
    input  wire logic [mwf_pkg::CH_W-1:0]              convChannel,
    input  wire logic [mwf_pkg::RESULT_W-1:0]          convResult,
    input  wire logic [mwf_pkg::NUM_CH-1:0][mwf_pkg::RESULT_W-1:0]
                                                       highThresh,
    input  wire logic [mwf_pkg::NUM_CH-1:0][mwf_pkg::RESULT_W-1:0]
                                                       lowThresh,
    input  wire logic                                  powerOnAnalogTrip,
    output logic [7:0]                                 warningFlagsPrimary,
    output logic [7:0]                                 warningFlagsSecondary
);
    import mwf_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] flagHigh;
    logic [NUM_CH-1:0] flagLow;
    logic [7:0]        control_q;
    logic              updateEn;
    logic              addrHit;
    logic              addrWritable;
    logic [31:0]       readValue;
    logic              writeStrobe;
    logic [7:0]        primaryValue;
    logic [7:0]        secondaryValue;

    logic              temperatureHighWarning;
    logic              temperatureLowWarning;
    logic              supplyHighWarning;
    logic              supplyLowWarning;
    logic              extMonitorAHighWarning;
    logic              extMonitorALowWarning;
    logic              extMonitorBHighWarning;
    logic              extMonitorBLowWarning;
    logic              extMonitorCHighWarning;
    logic              extMonitorCLowWarning;
    logic              extMonitorDHighWarning;
    logic              extMonitorDLowWarning;

    mwf_conv_if #(.W(RESULT_W)) convBus ();

    assign convBus.valid   = convValid;
    assign convBus.channel = convChannel;
    assign convBus.result  = convResult;

    assign updateEn = control_q[BIT_UPDATE_EN];

    // ------------------------------------------------------------------
    // Channel flag cells
    // ------------------------------------------------------------------
    // Only the supply cell sees the trip level; the others never force.
    for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
        mwf_chan_flags #(
            .CHANNEL   (CH_W'(i)),
            .W         (RESULT_W),
            .LOW_RESET (RST_PRIMARY[BIT_SUP_LO] && (i == int'(CH_SUPPLY)))
        ) u_flags (
            .core_clk   (core_clk),
            .srst       (srst),
            .conv       (convBus.sink),
            .updateEn   (updateEn),
            .highThresh (highThresh[i]),
            .lowThresh  (lowThresh[i]),
            .forceLow   ((i == int'(CH_SUPPLY)) && powerOnAnalogTrip),
            .highWarn   (flagHigh[i]),
            .lowWarn    (flagLow[i])
        );
    end

    assign temperatureHighWarning = flagHigh[CH_TEMP];
    assign temperatureLowWarning  = flagLow[CH_TEMP];
    assign supplyHighWarning      = flagHigh[CH_SUPPLY];
    assign supplyLowWarning       = flagLow[CH_SUPPLY];
    assign extMonitorAHighWarning = flagHigh[CH_EXT_A];
    assign extMonitorALowWarning  = flagLow[CH_EXT_A];
    assign extMonitorBHighWarning = flagHigh[CH_EXT_B];
    assign extMonitorBLowWarning  = flagLow[CH_EXT_B];
    assign extMonitorCHighWarning = flagHigh[CH_EXT_C];
    assign extMonitorCLowWarning  = flagLow[CH_EXT_C];
    assign extMonitorDHighWarning = flagHigh[CH_EXT_D];
    assign extMonitorDLowWarning  = flagLow[CH_EXT_D];

    // ------------------------------------------------------------------
    // Register images
    // ------------------------------------------------------------------
    always_comb begin
        primaryValue              = 8'h00;
        primaryValue[BIT_TEMPERATURE_HIGH_WARNING] = temperatureHighWarning;
        primaryValue[BIT_TEMPERATURE_LOW_WARNING] = temperatureLowWarning;
        primaryValue[BIT_SUP_HI]  = supplyHighWarning;
        primaryValue[BIT_SUP_LO]  = supplyLowWarning;
        primaryValue[BIT_EXTA_HI] = extMonitorAHighWarning;
        primaryValue[BIT_EXTA_LO] = extMonitorALowWarning;
        primaryValue[BIT_EXTB_HI] = extMonitorBHighWarning;
        primaryValue[BIT_EXTB_LO] = extMonitorBLowWarning;
    end

    // Reserved low nibble stays at its zero default.
    always_comb begin
        secondaryValue              = RST_SECONDARY;
        secondaryValue[BIT_EXTC_HI] = extMonitorCHighWarning;
        secondaryValue[BIT_EXTC_LO] = extMonitorCLowWarning;
        secondaryValue[BIT_EXTD_HI] = extMonitorDHighWarning;
        secondaryValue[BIT_EXTD_LO] = extMonitorDLowWarning;
    end

    assign warningFlagsPrimary   = primaryValue;
    assign warningFlagsSecondary = secondaryValue;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    always_comb begin
        addrHit      = 1'b1;
        addrWritable = 1'b0;
        readValue    = 32'h0000_0000;
        unique case (paddr)
            ADDR_PRIMARY: begin
                readValue = {24'h00_0000, primaryValue};
            end
            ADDR_SECONDARY: begin
                readValue = {24'h00_0000, secondaryValue};
            end
            ADDR_CONTROL: begin
                readValue    = {24'h00_0000, control_q};
                addrWritable = 1'b1;
            end
            default: begin
                addrHit = 1'b0;
            end
        endcase
    end

    // Only the update enable bit is implemented; other control bits read 0.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            control_q <= RST_CONTROL;
        end else if (writeStrobe && pstrb[0]) begin
            control_q <= {7'h00, pwdata[BIT_UPDATE_EN]};
        end
    end

    mwf_apb_slave u_apb (
        .core_clk     (core_clk),
        .srst         (srst),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .addrHit      (addrHit),
        .addrWritable (addrWritable),
        .readValue    (readValue),
        .pready       (pready),
        .prdata       (prdata),
        .pslverr      (pslverr),
        .writeStrobe  (writeStrobe)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence convOf(logic [2:0] ch);
        convValid && updateEn && (convChannel == ch);
    endsequence

    sequence apbRead(logic [11:0] addr);
        psel && !penable && !pwrite && (paddr == addr) ##1 psel && penable;
    endsequence

    // Writes are judged at the access cycle.
    sequence apbWrite(logic [11:0] addr);
        psel && !penable && pwrite && (paddr == addr) ##1 psel && penable;
    endsequence

    a_temp_high_cmp:
    assert property (convOf(CH_TEMP) |=> temperatureHighWarning ==
        ($past(convResult) > $past(highThresh[CH_TEMP])))
        else $error("temperature high flag wrong after conversion");

    a_temp_low_cmp:
    assert property (convOf(CH_TEMP) |=> temperatureLowWarning ==
        ($past(convResult) < $past(lowThresh[CH_TEMP])))
        else $error("temperature low flag wrong after conversion");

    a_supply_high_cmp:
    assert property (convOf(CH_SUPPLY) |=> supplyHighWarning ==
        ($past(convResult) > $past(highThresh[CH_SUPPLY])))
        else $error("supply high flag wrong after conversion");

    a_supply_low_force:
    assert property (powerOnAnalogTrip |=> supplyLowWarning [*2]
        or (supplyLowWarning ##1 !$past(powerOnAnalogTrip)))
        else $error("supply low flag not forced under trip level");

    a_supply_low_clear:
    assert property (convOf(CH_SUPPLY) and !powerOnAnalogTrip |=>
        supplyLowWarning == ($past(convResult) <
        $past(lowThresh[CH_SUPPLY])))
        else $error("supply low flag did not follow conversion");

    a_primary_reset_val:
    assert property (disable iff (1'b0) $fell(srst) |->
        warningFlagsPrimary == RST_PRIMARY
        || $past(powerOnAnalogTrip))
        else $error("primary register wrong after reset");

    a_exta_high_cmp:
    assert property (convOf(CH_EXT_A) |=> extMonitorAHighWarning ==
        ($past(convResult) > $past(highThresh[CH_EXT_A])))
        else $error("monitor A high flag wrong");

    a_exta_low_cmp:
    assert property (convOf(CH_EXT_A) |=> extMonitorALowWarning ==
        ($past(convResult) < $past(lowThresh[CH_EXT_A])))
        else $error("monitor A low flag wrong");

    a_extb_high_cmp:
    assert property (convOf(CH_EXT_B) |=> extMonitorBHighWarning ==
        ($past(convResult) > $past(highThresh[CH_EXT_B])))
        else $error("monitor B high flag wrong");

    a_extb_low_cmp:
    assert property (convOf(CH_EXT_B) |=> extMonitorBLowWarning ==
        ($past(convResult) < $past(lowThresh[CH_EXT_B])))
        else $error("monitor B low flag wrong");

    a_extc_high_read:
    assert property (convOf(CH_EXT_C) |=> warningFlagsSecondary[7] ==
        ($past(convResult) > $past(highThresh[CH_EXT_C])))
        else $error("monitor C high flag wrong in bit 7");

    a_extc_low_cmp:
    assert property (convOf(CH_EXT_C) |=> extMonitorCLowWarning ==
        ($past(convResult) < $past(lowThresh[CH_EXT_C])))
        else $error("monitor C low flag wrong");

    a_extd_high_cmp:
    assert property (convOf(CH_EXT_D) |=> extMonitorDHighWarning ==
        ($past(convResult) > $past(highThresh[CH_EXT_D])))
        else $error("monitor D high flag wrong");

    a_extd_low_cmp:
    assert property (convOf(CH_EXT_D) |=> extMonitorDLowWarning ==
        ($past(convResult) < $past(lowThresh[CH_EXT_D])))
        else $error("monitor D low flag wrong");

    a_flags_hold_idle:
    assert property (!(convValid && updateEn) && !powerOnAnalogTrip |=>
        $stable(flagHigh) && $stable(flagLow))
        else $error("flags changed without a conversion");

    a_secondary_rsvd_read:
    assert property (apbRead(ADDR_SECONDARY) |->
        prdata[3:0] == 4'h0 && pready && !pslverr)
        else $error("reserved secondary bits not zero on read");

    // Read data is loaded at the setup edge, so the access cycle
    // shows the flags of one cycle before.
    a_primary_read_data:
    assert property (apbRead(ADDR_PRIMARY) |->
        prdata == {24'h00_0000, $past(warningFlagsPrimary)})
        else $error("primary read data wrong");

    a_secondary_read_data:
    assert property (apbRead(ADDR_SECONDARY) |->
        prdata == {24'h00_0000, $past(warningFlagsSecondary)})
        else $error("secondary read data wrong");

    a_flag_read_ok:
    assert property ((apbRead(ADDR_PRIMARY) or apbRead(ADDR_SECONDARY))
        |-> !pslverr)
        else $error("flag register read was refused");

    // Flag registers are read-only.
    a_ro_write_refused:
    assert property ((apbWrite(ADDR_PRIMARY) or apbWrite(ADDR_SECONDARY))
        |-> pslverr)
        else $error("write to a flag register not refused");

    a_unmapped_refused:
    assert property (psel && !penable && !addrHit ##1 psel && penable |->
        pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    // Only byte lane 0 carries the update enable.
    a_control_write:
    assert property (apbWrite(ADDR_CONTROL) ##0 pstrb[0] |=>
        updateEn == $past(pwdata[BIT_UPDATE_EN]))
        else $error("control write did not land");

    a_strobe_gate:
    assert property (apbWrite(ADDR_CONTROL) ##0 !pstrb[0] |=>
        $stable(control_q))
        else $error("control changed with lane 0 off");

    // The trip is left out: it forces the supply flag at any time.
    a_temp_isolated:
    assert property (convOf(CH_TEMP) ##0 !powerOnAnalogTrip |=>
        $stable(flagHigh[NUM_CH-1:1]) && $stable(flagLow[NUM_CH-1:1]))
        else $error("temperature conversion moved other flags");

    a_extd_isolated:
    assert property (convOf(CH_EXT_D) ##0 !powerOnAnalogTrip |=>
        $stable(flagHigh[NUM_CH-2:0]) && $stable(flagLow[NUM_CH-2:0]))
        else $error("monitor D conversion moved other flags");

endmodule // mwf_warning_top
`default_nettype wire

//--- rtl/mwf_pkg.sv
// Shared constants for the monitor warning flag bank.
`default_nettype none
package mwf_pkg;
    // ------------------------------------------------------------------
    // Channels and data widths
    // ------------------------------------------------------------------
    localparam int          NUM_CH    = 6;
    localparam int          RESULT_W  = 16;
    localparam int          CH_W      = 3;
    localparam logic [2:0]  CH_TEMP   = 3'h0;
    localparam logic [2:0]  CH_SUPPLY = 3'h1;
    localparam logic [2:0]  CH_EXT_A  = 3'h2;
    localparam logic [2:0]  CH_EXT_B  = 3'h3;
    localparam logic [2:0]  CH_EXT_C  = 3'h4;
    localparam logic [2:0]  CH_EXT_D  = 3'h5;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 12;
    localparam logic [7:0]  IDX_PRIMARY   = 8'h74;
    localparam logic [7:0]  IDX_SECONDARY = 8'h75;
    localparam logic [11:0] ADDR_PRIMARY  = {2'h0, IDX_PRIMARY, 2'h0};
    localparam logic [11:0] ADDR_SECONDARY = {2'h0, IDX_SECONDARY, 2'h0};
    localparam logic [11:0] ADDR_CONTROL  = 12'h000;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_TEMPERATURE_HIGH_WARNING = 7;
    localparam int BIT_TEMPERATURE_LOW_WARNING = 6;
    localparam int BIT_SUP_HI  = 5;
    localparam int BIT_SUP_LO  = 4;
    localparam int BIT_EXTA_HI = 3;
    localparam int BIT_EXTA_LO = 2;
    localparam int BIT_EXTB_HI = 1;
    localparam int BIT_EXTB_LO = 0;
    localparam int BIT_EXTC_HI = 7;
    localparam int BIT_EXTC_LO = 6;
    localparam int BIT_EXTD_HI = 5;
    localparam int BIT_EXTD_LO = 4;
    localparam int BIT_UPDATE_EN = 0;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_PRIMARY   = 8'h10;
    localparam logic [7:0] RST_SECONDARY = 8'h00;
    localparam logic [7:0] RST_CONTROL   = 8'h01;
endpackage
`default_nettype wire

//--- rtl/mwf_conv_if.sv
// Conversion result carrier from the top level to the channel flag cells.
`default_nettype none
interface mwf_conv_if #(
    parameter int W = mwf_pkg::RESULT_W
);
    logic             valid;
    logic [2:0]       channel;
    logic [W-1:0]     result;

    modport src  (output valid, output channel, output result);
    modport sink (input valid, input channel, input result);
endinterface
`default_nettype wire

//--- rtl/mwf_chan_flags.sv
// High and low warning flag pair for one monitored channel.
`default_nettype none
module mwf_chan_flags
    import mwf_pkg::*;
#(
    parameter logic [2:0] CHANNEL   = 3'h0,
    parameter int         W         = RESULT_W,
    parameter logic       LOW_RESET = 1'b0
) (
    input  wire logic         core_clk,
    input  wire logic         srst,
    mwf_conv_if.sink          conv,
    input  wire logic         updateEn,
    input  wire logic [W-1:0] highThresh,
    input  wire logic [W-1:0] lowThresh,
    input  wire logic         forceLow,
    output var  logic         highWarn,
    output var  logic         lowWarn
);
    logic hit;

    assign hit = conv.valid && (conv.channel == CHANNEL) && updateEn;

    // Equal to the threshold counts as inside the band for both flags.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            highWarn <= 1'b0;
        end else if (hit) begin
            highWarn <= conv.result > highThresh;
        end
    end

    // The force term wins over a conversion that would clear the flag.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            lowWarn <= LOW_RESET;
        end else if (forceLow) begin
            lowWarn <= 1'b1;
        end else if (hit) begin
            lowWarn <= conv.result < lowThresh;
        end
    end
endmodule // mwf_chan_flags
`default_nettype wire

//--- rtl/mwf_apb_slave.sv
// APB slave front end with registered read data and zero wait states.
`default_nettype none
module mwf_apb_slave
    import mwf_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              srst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic              addrHit,
    input  wire logic              addrWritable,
    input  wire logic [31:0]       readValue,
    output logic                   pready,
    output var  logic [31:0]       prdata,
    output var  logic              pslverr,
    output logic                   writeStrobe
);
    logic setupPhase;
    logic accessPhase;
    logic errorSeen;

    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign pready      = accessPhase;
    assign pslverr     = accessPhase && errorSeen;
    assign writeStrobe = accessPhase && pwrite && !errorSeen;

    // Read data is captured in the setup cycle so it leaves a flip-flop.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase) begin
            prdata <= (addrHit && !pwrite) ? readValue : 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            errorSeen <= 1'b0;
        end else if (setupPhase) begin
            errorSeen <= !addrHit || (pwrite && !addrWritable);
        end
    end
endmodule // mwf_apb_slave
`default_nettype wire

//--- verif/tb_monitor_warning_flags.sv
// Self-checking bench for the monitor warning flag register bank.
`default_nettype none
module tb_monitor_warning_flags;
    timeunit 1ns;
    timeprecision 1ps;
    import mwf_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                               core_clk;
    logic                               srst;
    logic                               psel;
    logic                               penable;
    logic                               pwrite;
    logic [ADDR_W-1:0]                  paddr;
    logic [31:0]                        pwdata;
    logic [3:0]                         pstrb;
    logic                               pready;
    logic [31:0]                        prdata;
    logic                               pslverr;
    logic                               convValid;
    logic [CH_W-1:0]                    convChannel;
    logic [RESULT_W-1:0]                convResult;
    logic [NUM_CH-1:0][RESULT_W-1:0]    highThresh;
    logic [NUM_CH-1:0][RESULT_W-1:0]    lowThresh;
    logic                               powerOnAnalogTrip;
    logic [7:0]                         warningFlagsPrimary;
    logic [7:0]                         warningFlagsSecondary;
    logic [7:0]                         expP;
    logic [7:0]                         expS;
    logic [31:0]                        rd;
    logic                               er;
    int                                 nFail;
    int                                 nTests;
    int hiPos [NUM_CH] = '{BIT_TEMPERATURE_HIGH_WARNING, BIT_SUP_HI, BIT_EXTA_HI,
                           BIT_EXTB_HI, BIT_EXTC_HI, BIT_EXTD_HI};
    int loPos [NUM_CH] = '{BIT_TEMPERATURE_LOW_WARNING, BIT_SUP_LO, BIT_EXTA_LO,
                           BIT_EXTB_LO, BIT_EXTC_LO, BIT_EXTD_LO};
    bit inSec [NUM_CH] = '{0, 0, 0, 0, 1, 1};

    mwf_warning_top dut (
        .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .convValid(convValid), .convChannel(convChannel),
        .convResult(convResult), .highThresh(highThresh),
        .lowThresh(lowThresh), .powerOnAnalogTrip(powerOnAnalogTrip),
        .warningFlagsPrimary(warningFlagsPrimary),
        .warningFlagsSecondary(warningFlagsSecondary)
    );

    always #5 core_clk = ~core_clk;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        nTests++;
        if (got !== exp) begin
            nFail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Entered just after a rising edge; returns just after one.
    task automatic apb(input logic wr, input logic [11:0] addr,
                       input logic [31:0] data, input logic [3:0] strb);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        pstrb   <= strb;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic conv(input int ch, input logic [15:0] res);
        convValid   <= 1'b1;
        convChannel <= 3'(ch);
        convResult  <= res;
        @(posedge core_clk);
        convValid   <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic set_exp(input int ch, input logic hi, input logic lo);
        if (inSec[ch]) begin
            expS[hiPos[ch]] = hi;
            expS[loPos[ch]] = lo;
        end else begin
            expP[hiPos[ch]] = hi;
            expP[loPos[ch]] = lo;
        end
    endtask

    task automatic chk_regs();
        apb(1'b0, ADDR_PRIMARY, 32'h0, 4'h0);
        check("primary", {24'h0, expP}, rd);
        check("primary err", 32'h0, {31'h0, er});
        check("primary port", {24'h0, expP}, {24'h0, warningFlagsPrimary});
        apb(1'b0, ADDR_SECONDARY, 32'h0, 4'h0);
        check("secondary", {24'h0, expS}, rd);
        check("secondary port", {24'h0, expS},
              {24'h0, warningFlagsSecondary});
    endtask

    task automatic do_reset(input int cycles);
        srst <= 1'b1;
        repeat (cycles) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        expP = 8'h10;
        expS = 8'h00;
    endtask

    task automatic end_of_test();
        $display("Counts: %0d checks, %0d mismatches", nTests, nFail);
        if (nFail == 0 && nTests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        srst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {convValid, convChannel, convResult, powerOnAnalogTrip} = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            highThresh[i] = 16'h8000 + 16'(i * 16);
            lowThresh[i]  = 16'h4000 + 16'(i * 16);
        end
        do_reset(12);
        chk_regs();
        $display("Test reset values done");
        // Each channel ends with its low flag set, so later channels
        // also show that earlier pairs are left alone.
        for (int c = 0; c < NUM_CH; c++) begin
            conv(c, highThresh[c]);
            set_exp(c, 1'b0, 1'b0);
            chk_regs();
            conv(c, lowThresh[c]);
            chk_regs();
            conv(c, highThresh[c] + 16'h1);
            set_exp(c, 1'b1, 1'b0);
            chk_regs();
            conv(c, lowThresh[c] - 16'h1);
            set_exp(c, 1'b0, 1'b1);
            chk_regs();
        end
        $display("Test threshold compares done");
        // The trip wins over a clearing supply result in the same cycle.
        powerOnAnalogTrip <= 1'b1;
        conv(CH_SUPPLY, highThresh[CH_SUPPLY] + 16'h1);
        set_exp(CH_SUPPLY, 1'b1, 1'b1);
        chk_regs();
        powerOnAnalogTrip <= 1'b0;
        @(posedge core_clk);
        chk_regs();
        conv(CH_SUPPLY, lowThresh[CH_SUPPLY] + 16'h1);
        set_exp(CH_SUPPLY, 1'b0, 1'b0);
        chk_regs();
        $display("Test power-on trip done");
        apb(1'b0, ADDR_CONTROL, 32'h0, 4'h0);
        check("control reset", 32'h1, rd);
        apb(1'b1, ADDR_CONTROL, 32'h0, 4'h1);
        conv(CH_TEMP, 16'hFFFF);
        chk_regs();
        apb(1'b1, ADDR_CONTROL, 32'h1, 4'h1);
        conv(6, 16'h0000);
        conv(7, 16'hFFFF);
        chk_regs();
        apb(1'b1, ADDR_CONTROL, 32'h0, 4'hE);
        apb(1'b0, ADDR_CONTROL, 32'h0, 4'h0);
        check("control strobe", 32'h1, rd);
        $display("Test update gating done");
        convValid   <= 1'b1;
        convChannel <= 3'(CH_EXT_A);
        convResult  <= highThresh[CH_EXT_A] + 16'h2;
        @(posedge core_clk);
        convChannel <= 3'(CH_EXT_D);
        convResult  <= highThresh[CH_EXT_D] + 16'h2;
        @(posedge core_clk);
        convValid   <= 1'b0;
        @(posedge core_clk);
        set_exp(CH_EXT_A, 1'b1, 1'b0);
        set_exp(CH_EXT_D, 1'b1, 1'b0);
        chk_regs();
        $display("Test back-to-back conversions done");
        apb(1'b1, ADDR_PRIMARY, 32'hFF, 4'hF);
        check("write primary err", 32'h1, {31'h0, er});
        apb(1'b1, ADDR_SECONDARY, 32'hFF, 4'hF);
        check("write secondary err", 32'h1, {31'h0, er});
        apb(1'b0, 12'h100, 32'h0, 4'h0);
        check("unmapped err", 32'h1, {31'h0, er});
        check("unmapped data", 32'h0, rd);
        chk_regs();
        $display("Test refused accesses done");
        do_reset(2);
        chk_regs();
        $display("Test second reset done");
        end_of_test();
    end

    initial begin
        #200000;
        nFail++;
        $display("BAD watchdog expected done seen hang");
        end_of_test();
    end
endmodule // tb_monitor_warning_flags
`default_nettype wire
